// ---- rtl/nvram_pkg.sv ----
// shared constants and types for the serial nvram two-wire slave
package nvram_pkg;

  // ==========================================================
  // array geometry
  localparam int          ADDR_W    = 15;
  localparam int          DATA_W    = 8;
  localparam int          MEM_DEPTH = 32768;
  localparam logic [14:0] ADDR_RST  = 15'h0000;

  // ==========================================================
  // first-byte field layout
  localparam int         TYPE_MSB  = 7;
  localparam int         TYPE_LSB  = 4;
  localparam int         SEL_MSB   = 3;
  localparam int         SEL_LSB   = 1;
  localparam int         RW_BIT    = 0;
  localparam logic [4:0] HS_CODE   = 5'h01;  // upper five bits 00001
  localparam int         HS_LSB    = 3;
  localparam int         HI_ADDR_W = 7;

  // ==========================================================
  // id stream lengths in bytes
  localparam logic [3:0] ID_LEN = 4'h3;
  localparam logic [3:0] SN_LEN = 4'h8;

  // ==========================================================
  // timing: bus rates and reference clock
  localparam int REF_CLK_HZ  = 40_000_000;
  localparam int SCL_SM_HZ   = 100_000;
  localparam int SCL_FM_HZ   = 400_000;
  localparam int SCL_HS_HZ   = 3_400_000;
  // whole reference cycles in one half of the fastest serial clock
  localparam int HS_HALF_CYC = REF_CLK_HZ / (2 * SCL_HS_HZ);

  // ==========================================================
  // pin synchroniser reset values {sel[2:0], wp, sda, scl}
  localparam logic [5:0] PIN_RST = 6'h03;
  localparam logic [3:0] CNT_BYTE = 4'h8;

  // ==========================================================
  // states and access modes
  typedef enum logic [2:0] {
    S_IDLE, S_RECV, S_ACK, S_SEND, S_MACK, S_SKIP
  } slave_state_e;

  typedef enum logic {M_MEM, M_ID} access_mode_e;

endpackage : nvram_pkg

// ---- rtl/bus_evt_if.sv ----
// synchronised pin levels and bus events between pin stage and slave
`timescale 1ns/10ps
interface bus_evt_if;
  logic       scl;
  logic       sda;
  logic       wp;
  logic [2:0] sel;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;

  modport src (output scl, sda, wp, sel, scl_rise, scl_fall, start, stop);
  modport dst (input  scl, sda, wp, sel, scl_rise, scl_fall, start, stop);
endinterface : bus_evt_if

// ---- rtl/nvram_pin_sync.sv ----
// two-flop pin synchroniser and serial bus event detector
`timescale 1ns/10ps
module nvram_pin_sync
  import nvram_pkg::*;
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  // raw pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_wp,
  input  wire logic [2:0] i_device_select_pins,
  // events toward the slave
  bus_evt_if.src          ev
);

  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic [1:0] prev_q;

  // ==========================================================
  // synchronisers: first stage feeds only the second
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      meta_q <= PIN_RST;
      sync_q <= PIN_RST;
    end else begin
      meta_q <= {i_device_select_pins, i_wp, i_sda, i_scl};
      sync_q <= meta_q;
    end
  end

  // previous scl and sda for edge detection
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      prev_q <= 2'h3;
    end else begin
      prev_q <= sync_q[1:0];
    end
  end

  // ==========================================================
  // levels; wp and select default low via pad pull-downs
  assign ev.scl = sync_q[0];
  assign ev.sda = sync_q[1];
  assign ev.wp  = sync_q[2];
  assign ev.sel = sync_q[5:3];

  // edges; 40 MHz sampling leaves five cycles per high-speed half period
  assign ev.scl_rise = sync_q[0] & ~prev_q[0];
  assign ev.scl_fall = ~sync_q[0] & prev_q[0];
  assign ev.start    = sync_q[0] & prev_q[0] & prev_q[1] & ~sync_q[1];
  assign ev.stop     = sync_q[0] & prev_q[0] & ~prev_q[1] & sync_q[1];

  // start and stop need scl high on both samples
  AST_START_SCL_HIGH: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b) ev.start |-> ev.scl && $past(ev.scl))
    else $error("start seen while scl was not high");

endmodule : nvram_pin_sync

// ---- rtl/nvram_i2c_slave.sv ----
// two-wire serial slave front end of a 32k x 8 nonvolatile ram
`timescale 1ns/10ps
module nvram_i2c_slave
  import nvram_pkg::*;
#(
  parameter int          DEPTH      = MEM_DEPTH,
  parameter bit          HAS_SERIAL = 1'b0,
  // identification values below are arbitrary
  parameter logic [3:0]  MEM_TYPE   = 4'hC,
  parameter logic [3:0]  ID_TYPE    = 4'hF,
  parameter logic [23:0] DEV_ID     = 24'h5A3C01,
  parameter logic [63:0] SERIAL_NUM = 64'h0123456789ABCDEF
)
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  // serial bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  // strap pins
  input  wire logic       i_wp,
  input  wire logic [2:0] i_device_select_pins,
  // status
  output logic            o_hs_mode
);

  // ==========================================================
  // declarations
  localparam logic [87:0] ID_STREAM = {DEV_ID, SERIAL_NUM};
  localparam logic [3:0]  ID_TOTAL  = HAS_SERIAL ? ID_LEN + SN_LEN : ID_LEN;

  bus_evt_if ev ();

  slave_state_e          state_q;
  access_mode_e          mode_q;
  logic [3:0]            cnt_q;
  logic [1:0]            idx_q;
  logic [DATA_W-1:0]     shift_q;
  logic [DATA_W-1:0]     tx_q;
  logic [ADDR_W-1:0]     addr_q;
  logic [3:0]            id_idx_q;
  logic                  rw_q;
  logic                  sda_oe_q;
  logic                  sda_o_q;
  logic                  hs_q;
  logic [DATA_W-1:0]     mem_q [DEPTH];

  logic                  rx_done;
  logic                  tx_done;
  logic                  hs_hit;
  logic                  sel_hit;
  logic                  mem_hit;
  logic                  id_hit;
  logic                  mem_we;
  logic [DATA_W-1:0]     id_byte;
  logic [DATA_W-1:0]     rd_byte;

  // ==========================================================
  // pin stage
  nvram_pin_sync u_pin_sync (
    .i_ref_clk            (i_ref_clk),
    .i_rst_b              (i_rst_b),
    .i_scl                (i_scl),
    .i_sda                (i_sda),
    .i_wp                 (i_wp),
    .i_device_select_pins (i_device_select_pins),
    .ev                   (ev)
  );

  // ==========================================================
  // byte decode
  assign rx_done = (state_q == S_RECV) && (cnt_q == CNT_BYTE)
                   && ev.scl_fall;
  assign tx_done = (state_q == S_SEND) && (cnt_q == CNT_BYTE)
                   && ev.scl_fall;
  assign hs_hit  = (shift_q[TYPE_MSB:HS_LSB] == HS_CODE);
  assign sel_hit = (shift_q[SEL_MSB:SEL_LSB] == ev.sel);
  assign mem_hit = sel_hit && (shift_q[TYPE_MSB:TYPE_LSB] == MEM_TYPE);
  // the id space answers reads only, so it can never be written
  assign id_hit  = sel_hit && (shift_q[TYPE_MSB:TYPE_LSB] == ID_TYPE)
                   && shift_q[RW_BIT];

  // write strobe: only data bytes, only while unprotected
  assign mem_we  = rx_done && (idx_q == 2'h3) && (mode_q == M_MEM)
                   && !ev.wp;

  // read source: array or id/serial stream
  assign id_byte = ID_STREAM[8*(10 - 32'(id_idx_q)) +: 8];
  assign rd_byte = (mode_q == M_ID) ? id_byte : mem_q[addr_q];

  // ==========================================================
  // transaction state machine
  // start always wins, so a new command may follow a write at once
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state_q  <= S_IDLE;
      mode_q   <= M_MEM;
      cnt_q    <= 4'h0;
      idx_q    <= 2'h0;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      rw_q     <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (ev.start) begin
      state_q  <= S_RECV;
      cnt_q    <= 4'h0;
      idx_q    <= 2'h0;
      rw_q     <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (ev.stop) begin
      state_q  <= S_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE, S_SKIP: begin
          sda_oe_q <= 1'b0;
        end
        S_RECV: begin
          if (ev.scl_rise) begin
            shift_q <= {shift_q[6:0], ev.sda};
            cnt_q   <= cnt_q + 4'h1;
          end else if (rx_done) begin
            if (idx_q != 2'h0) begin
              // address and data bytes, protected or not
              state_q  <= S_ACK;
              sda_oe_q <= 1'b1;
              if (idx_q != 2'h3) begin
                idx_q <= idx_q + 2'h1;
              end
            end else if (hs_hit) begin
              state_q <= S_SKIP;        // master code is never acknowledged
            end else if (mem_hit || id_hit) begin
              state_q  <= S_ACK;
              sda_oe_q <= 1'b1;
              rw_q     <= shift_q[RW_BIT];
              mode_q   <= mem_hit ? M_MEM : M_ID;
              idx_q    <= 2'h1;
            end else begin
              state_q <= S_SKIP;
            end
          end
        end
        S_ACK: begin
          if (ev.scl_fall) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              state_q  <= S_SEND;
              tx_q     <= rd_byte;
              sda_oe_q <= !rd_byte[7];
            end else begin
              state_q  <= S_RECV;
              sda_oe_q <= 1'b0;
            end
          end
        end
        S_SEND: begin
          if (ev.scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (tx_done) begin
            state_q  <= S_MACK;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b0;
          end else if (ev.scl_fall) begin
            tx_q     <= {tx_q[6:0], 1'b0};
            sda_oe_q <= !tx_q[6];
          end
        end
        S_MACK: begin
          if (ev.scl_rise) begin
            // master nack ends the read; wait for stop or start
            if (ev.sda) begin
              state_q <= S_SKIP;
            end else begin
              cnt_q <= 4'h1;
            end
          end else if (ev.scl_fall && (cnt_q == 4'h1)) begin
            state_q  <= S_SEND;
            cnt_q    <= 4'h0;
            tx_q     <= rd_byte;
            sda_oe_q <= !rd_byte[7];
          end
        end
      endcase
    end
  end

  // ==========================================================
  // address latch: loaded by a write, bumped at the end of each array data byte
  // the 15-bit add wraps 7FFFh to 0000h by itself
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      addr_q <= ADDR_RST;
    end else if (rx_done && (idx_q == 2'h1)) begin
      addr_q[ADDR_W-1:8] <= shift_q[HI_ADDR_W-1:0];
    end else if (rx_done && (idx_q == 2'h2)) begin
      addr_q[7:0] <= shift_q;
    end else if ((rx_done && (idx_q == 2'h3) && (mode_q == M_MEM))
                 || (tx_done && (mode_q == M_MEM))) begin
      addr_q <= addr_q + 15'h0001;
    end
  end

  // ==========================================================
  // id stream pointer, restarted on every id selection
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      id_idx_q <= 4'h0;
    end else if (rx_done && (idx_q == 2'h0)) begin
      id_idx_q <= 4'h0;
    end else if (tx_done && (mode_q == M_ID)) begin
      id_idx_q <= (id_idx_q == ID_TOTAL - 4'h1) ? 4'h0
                                                : id_idx_q + 4'h1;
    end
  end

  // ==========================================================
  // array storage; no reset, contents are the nonvolatile data
  // the byte lands on the same edge that closes its 8th bit
  always_ff @(posedge i_ref_clk) begin
    if (mem_we) begin
      mem_q[addr_q] <= shift_q;
    end
  end

  // ==========================================================
  // high-speed mode flag
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      hs_q <= 1'b0;
    end else if (ev.stop) begin
      hs_q <= 1'b0;
    end else if (rx_done && (idx_q == 2'h0) && hs_hit) begin
      hs_q <= 1'b1;
    end
  end

  // open-drain: the data value is always low, only the enable moves
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign o_sda_o   = sda_o_q;
  assign o_sda_oe  = sda_oe_q;
  assign o_hs_mode = hs_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  AST_OPEN_DRAIN: assert property (
    o_sda_oe |-> !o_sda_o)
    else $error("data line driven high");

  AST_DRIVE_ON_FALL: assert property (
    $rose(sda_oe_q) |-> $past(ev.scl_fall))
    else $error("data line pulled low away from a scl fall");

  AST_WP_BLOCKS: assert property (
    ev.wp |-> !mem_we)
    else $error("array written while protected");

  AST_NO_SELECT: assert property (
    (rx_done && idx_q == 2'h0 && !sel_hit)
    |=> (state_q == S_SKIP) && !sda_oe_q [*4])
    else $error("unselected device acknowledged");

  AST_LATCH_BUMP: assert property (
    (rx_done && idx_q == 2'h3)
    |=> addr_q == $past(addr_q) + 15'h0001)
    else $error("address latch did not advance after data byte");

  AST_COMMIT: assert property (
    mem_we |=> mem_q[$past(addr_q)] == $past(shift_q))
    else $error("written byte not committed on the next edge");

  AST_ID_NO_WRITE: assert property (
    (rx_done && idx_q == 2'h0 && !shift_q[RW_BIT]
     && shift_q[TYPE_MSB:TYPE_LSB] == ID_TYPE)
    |=> !sda_oe_q && state_q == S_SKIP)
    else $error("write to id space acknowledged");

  AST_HS_EXIT: assert property (
    ev.stop |=> !o_hs_mode)
    else $error("high-speed mode kept after stop");

  AST_ACK_HOLD: assert property (
    (rx_done && idx_q == 2'h3) |=> (state_q == S_ACK) && sda_oe_q)
    else $error("data byte not acknowledged");

  // ack stands for the whole ack state, left at a scl fall, a start or a stop
  AST_ACK_STAND: assert property (
    (state_q == S_ACK) |-> sda_oe_q)
    else $error("acknowledge released before scl fall");

  COV_WRITE: cover property (mem_we);
  COV_WP_WRITE: cover property (rx_done && idx_q == 2'h3 && ev.wp);
  COV_READ: cover property (tx_done && mode_q == M_MEM);
  COV_ID_READ: cover property (tx_done && mode_q == M_ID);
  COV_HS: cover property ($rose(hs_q));

endmodule : nvram_i2c_slave

// ---- dv/i2c_master_model.sv ----
// two-wire bus master model that drives the serial clock and data line
`timescale 1ns/10ps
module i2c_master_model (
  // clock
  input  wire logic i_ref_clk,
  // bus
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // ==========================================
  // idle bus: clock stands high, data released
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  // wait n reference edges, then a fixed small skew
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #2;
  endtask : step

  // ==========================================
  // one bit, 6 cycles low and 2 high per 200 ns
  // low phase is long so the slave's reply settles before the rise
  task automatic bit_io(input logic v, output logic r);
    step(1);
    o_sda_oe = ~v;  // open drain: only pulls low
    step(5);
    o_scl = 1'b1;
    step(1);
    r = i_sda;  // sampled while clock is high
    step(1);
    o_scl = 1'b0;
  endtask : bit_io

  // start, also used as repeated start
  // clock stays low long enough for the slave to drop its ack first,
  // else its release would look like a stop with the clock high
  task automatic bus_start();
    o_sda_oe = 1'b0;
    step(6);
    o_scl = 1'b1;
    step(4);
    o_sda_oe = 1'b1;  // data falls while clock high
    step(4);
    o_scl = 1'b0;
  endtask : bus_start

  // stop leaves the bus idle; next frame may follow at once
  task automatic bus_stop();
    step(1);
    o_sda_oe = 1'b1;
    step(5);
    o_scl = 1'b1;
    step(4);
    o_sda_oe = 1'b0;  // data rises while clock high
    step(4);
  endtask : bus_stop

  // byte out, msb first, then read the acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put_byte

  // byte in, msb first, then acknowledge or not
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~ack, r);
  endtask : get_byte
endmodule : i2c_master_model

// ---- dv/serial_nvram_i2c_slave_tb_top.sv ----
// self-checking testbench of the two-wire nvram slave
`timescale 1ns/10ps
module serial_nvram_i2c_slave_tb_top;
  import nvram_pkg::*;
  // ==========================================
  // identity values below are arbitrary
  localparam logic [23:0] T_ID  = 24'h1E2D3C;
  localparam logic [63:0] T_SN  = 64'h0F1E2D3C4B5A6978;
  localparam logic [3:0]  MT    = 4'h6;
  localparam logic [3:0]  IT    = 4'h9;
  localparam int          LIMIT = 40000;

  logic       clk;
  logic       rst_b;
  logic       scl;
  logic       m_oe;
  logic       sda;
  logic       sda_o;
  logic       sda_oe;
  logic       wp;
  logic       hs;
  logic       oe_q = 1'b0;
  logic [2:0] sel;
  int         error_cnt = 0;
  int         n_tests = 0;
  int         cyc = 0;

  // pull-up: low when any party enables
  assign sda = ~(m_oe | sda_oe);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  nvram_i2c_slave #(
    .HAS_SERIAL (1'b1),
    .MEM_TYPE   (MT),
    .ID_TYPE    (IT),
    .DEV_ID     (T_ID),
    .SERIAL_NUM (T_SN)
  ) DUT (
    .i_ref_clk            (clk),
    .i_rst_b              (rst_b),
    .i_scl                (scl),
    .i_sda                (sda),
    .o_sda_o              (sda_o),
    .o_sda_oe             (sda_oe),
    .i_wp                 (wp),
    .i_device_select_pins (sel),
    .o_hs_mode            (hs)
  );

  i2c_master_model mst (
    .i_ref_clk (clk),
    .i_sda     (sda),
    .o_scl     (scl),
    .o_sda_oe  (m_oe)
  );

  // ==========================================
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // hang guard and pin watch; pin level may flip only in clock low
  always @(posedge clk) begin
    cyc++;
    if (cyc >= LIMIT) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      summarize();
    end
    if (rst_b === 1'b1) begin
      if (sda_oe === 1'b1 && sda_o !== 1'b0) begin
        error_cnt++;
        $display("Error at %0t: data pin driven high", $time);
      end
      if (sda_oe !== oe_q && scl === 1'b1) begin
        error_cnt++;
        $display("Error at %0t: data changed, clock high", $time);
      end
      oe_q = sda_oe;
    end
  end

  // ==========================================
  // bus helpers
  task automatic put(input logic [7:0] b, input logic exp);
    logic a;
    mst.put_byte(b, a);
    chk(a, exp, "ack");
  endtask : put

  task automatic set_addr(input logic [14:0] a);
    mst.bus_start();
    put({MT, sel, 1'b0}, 1'b1);
    put({1'b0, a[14:8]}, 1'b1);
    put(a[7:0], 1'b1);
  endtask : set_addr

  task automatic wr(input logic [14:0] a, input logic [7:0] d[$]);
    set_addr(a);
    foreach (d[i]) put(d[i], 1'b1);
    mst.bus_stop();
  endtask : wr

  task automatic rd(input logic [14:0] a, input logic [7:0] d[$]);
    logic [7:0] b;
    set_addr(a);
    mst.bus_start();
    put({MT, sel, 1'b1}, 1'b1);
    foreach (d[i]) begin
      mst.get_byte(i != d.size() - 1, b);
      chk(b, d[i], "read data");
    end
    mst.bus_stop();
  endtask : rd

  task automatic drive(input logic w, input logic [2:0] s);
    @(posedge clk);
    #2;
    wp  = w;
    sel = s;
  endtask : drive

  // ==========================================
  // scenarios
  task automatic t_basic();
    wr(15'h1234, '{8'hA5, 8'h3C, 8'h0F});
    rd(15'h1234, '{8'hA5, 8'h3C, 8'h0F});
    wr(15'h7FFF, '{8'h11, 8'h22});
    rd(15'h7FFF, '{8'h11});
    rd(15'h0000, '{8'h22});
  endtask : t_basic

  task automatic t_sel();
    for (int s = 0; s < 8; s++) begin
      drive(1'b0, s[2:0]);
      mst.bus_start();
      put({MT, s[2:0], 1'b0}, 1'b1);
      mst.bus_stop();
      mst.bus_start();
      put({MT, s[2:0] ^ 3'h1, 1'b0}, 1'b0);
      put(8'h00, 1'b0);
      mst.bus_stop();
    end
    drive(1'b0, 3'h0);
    mst.bus_start();
    put({4'h3, 3'h0, 1'b0}, 1'b0);
    mst.bus_stop();
    wr(15'h0042, '{8'h77});
    rd(15'h0042, '{8'h77});
  endtask : t_sel

  task automatic t_wp();
    wr(15'h0100, '{8'hAA, 8'hBB});
    drive(1'b1, sel);
    set_addr(15'h0100);
    put(8'hCC, 1'b1);
    drive(1'b0, sel);
    put(8'hDD, 1'b1);
    mst.bus_stop();
    rd(15'h0100, '{8'hAA, 8'hDD});
  endtask : t_wp

  task automatic t_id();
    logic [87:0] idv;
    logic [7:0]  b;
    idv = {T_ID, T_SN};
    mst.bus_start();
    put({IT, sel, 1'b1}, 1'b1);
    for (int k = 0; k < 12; k++) begin
      mst.get_byte(k != 11, b);
      chk(b, idv[87 - 8 * (k % 11) -: 8], "id");
    end
    mst.bus_stop();
    mst.bus_start();
    put({IT, sel, 1'b0}, 1'b0);
    mst.bus_stop();
    mst.bus_start();
    put({IT, sel, 1'b1}, 1'b1);
    mst.get_byte(1'b0, b);
    chk(b, T_ID[23:16], "id after write");
    mst.bus_stop();
  endtask : t_id

  task automatic t_hs();
    chk(hs, 1'b0, "hs idle");
    mst.bus_start();
    put(8'h0D, 1'b0);
    chk(hs, 1'b1, "hs set");
    set_addr(15'h0200);
    put(8'h5A, 1'b1);
    chk(hs, 1'b1, "hs held");
    mst.bus_stop();
    chk(hs, 1'b0, "hs cleared");
    rd(15'h0200, '{8'h5A});
  endtask : t_hs

  // ==========================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    wp    = 1'b0;
    sel   = 3'h0;
    repeat (16) @(posedge clk);
    #2;
    rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    chk(sda_oe, 1'b0, "oe after reset");
    t_basic();
    t_sel();
    t_wp();
    t_id();
    t_hs();
    summarize();
  end
endmodule : serial_nvram_i2c_slave_tb_top
